// file: rtl/pb_alt_pkg.sv
package pb_alt_pkg;
    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int PORT_W = 8;           // pins in the port
    localparam int SYNC_STAGES = 2;      // flops ahead of pin logic

    // ------------------------------------------------------------
    // pin positions of the alternate functions
    // ------------------------------------------------------------
    localparam int BIT_SCLK = 7;         // serial clock, stage 0b
    localparam int BIT_STAGE1B = 6;      // stage output 1b
    localparam int BIT_IRQ2 = 5;         // external interrupt 2
    localparam int BIT_AMP0P = 4;        // amplifier 0 plus input
    localparam int BIT_AMP0N = 3;        // amplifier 0 minus input
    localparam int BIT_IRQ1 = 2;         // external interrupt 1
    localparam int BIT_MOSI = 1;         // serial data, stage 2b
    localparam int BIT_MISO = 0;         // serial data, stage 2a

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_OE_N = 8'hff;   // not driving
    localparam logic [PORT_W-1:0] RST_ZERO = 8'h00;   // low / off
    localparam logic [1:0] LIVE_DONE = 2'h3;          // settle count
endpackage

// file: rtl/port_b_alternate_override.sv
`timescale 1ns/100ps
// What this block does
// - slave mode forces serial clock pin input unless stage 0b is enabled
// - master mode: clock pin follows direction bit
// - forced clock pin pull-up follows output bit and global disable
// - slave mode forces data-in pin bit 1 input
// - master mode: bit 1 follows direction bit
// - forced bit 1 pull-up: output bit, global disable
// - master mode forces bit 0 input
// - slave mode: bit 0 follows direction bit
// - forced bit 0 pull-up: output bit, global disable
// - bit 7 driver override from slave or stage
// - bit 7 driven value from stage 0b terms
// - serial clock in from bit 7, gated
// - serial data in from bit 1, gated
// - serial data in from bit 0, gated
// - stage 1b enable drives bit 6 out
// - analog disables turn off digital inputs
// - bit 5 feeds irq 2, forced on
// - bit 2 feeds irq 1, forced on
// - amplifier 0 disable kills bits 4, 3
// - every pin is a pin-change source
// - bits 0, 1 carry stage 2a, 2b
// - default pull-up only for 0b010 pattern
// - direction override decides driver enable
// - value override replaces output bit
// - input override beats sleep state
module port_b_alternate_override
(
    input  wire logic                        MCLK,   // i/o clock
    input  wire logic                        RESET,  // async, high
    input  wire logic [pb_alt_pkg::PORT_W-1:0] DIR,  // direction bits
    input  wire logic [pb_alt_pkg::PORT_W-1:0] OUT,  // output bits
    input  wire logic                 GLOBAL_PULLUP_DISABLE, // all off
    input  wire logic                 SLEEP,         // clamp inputs
    input  wire logic                 SERIAL_PERIPH_ON,      // spi on
    input  wire logic                 SERIAL_MASTER_SELECT,  // master
    input  wire logic                 SERIAL_PIN_SET_SELECT, // alt set
    input  wire logic                 STAGE_OUT_B0_ENABLE,   // 0b en
    input  wire logic                 STAGE_OUT_B0_VALUE,    // 0b val
    input  wire logic                 STAGE_OUT_B1_ENABLE,   // 1b en
    input  wire logic                 STAGE_OUT_B1_VALUE,    // 1b val
    input  wire logic                 STAGE_OUT_A2_ENABLE,   // 2a en
    input  wire logic                 STAGE_OUTPUT_TWO_A,    // 2a val
    input  wire logic                 STAGE_OUT_B2_ENABLE,   // 2b en
    input  wire logic                 STAGE_OUTPUT_TWO_B,    // 2b val
    input  wire logic                 ANALOG4_INPUT_DISABLE, // ch 4
    input  wire logic                 ANALOG5_INPUT_DISABLE, // ch 5
    input  wire logic                 ANALOG6_INPUT_DISABLE, // ch 6
    input  wire logic                 ANALOG7_INPUT_DISABLE, // ch 7
    input  wire logic                 AMP0_INPUT_DISABLE,    // amp 0
    input  wire logic                 EXT_IRQ2_ENABLE,       // irq 2
    input  wire logic                 EXT_IRQ1_ENABLE,       // irq 1
    input  wire logic                 CLOCK_IN_GATE_QUAL,    // clk gate
    input  wire logic                 DATA_IN_GATE_QUAL,     // data gate
    input  wire logic [pb_alt_pkg::PORT_W-1:0] PIN_IN,   // pad level
    output logic [pb_alt_pkg::PORT_W-1:0] PIN_OUT,       // pad value
    output logic [pb_alt_pkg::PORT_W-1:0] PIN_OE_N,      // low=drive
    output logic [pb_alt_pkg::PORT_W-1:0] PIN_PULLUP,    // pull-up on
    output logic [pb_alt_pkg::PORT_W-1:0] DIG_IN,        // gated input
    output logic [pb_alt_pkg::PORT_W-1:0] PIN_CHANGE_SRC, // pcint srcs
    output logic                 EXT_IRQ_2,         // irq 2 source
    output logic                 EXT_IRQ_1,         // irq 1 source
    output logic                 SERIAL_CLOCK_IN,   // spi clock in
    output logic                 SERIAL_DATA_IN_MOSI, // spi mosi in
    output logic                 SERIAL_DATA_IN_MISO  // spi miso in
);
    import pb_alt_pkg::*;
    // checks below all run on the i/o clock and pause in reset
    default clocking chk_clk @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------
    // override vectors, one bit per pin
    // ------------------------------------------------------------
    logic [PORT_W-1:0] pullup_override_en;    // pull-up takeover
    logic [PORT_W-1:0] pullup_override_val;   // pull-up value
    logic [PORT_W-1:0] dir_override_en;       // driver takeover
    logic [PORT_W-1:0] dir_override_val;      // driver value
    logic [PORT_W-1:0] value_override_en;     // value takeover
    logic [PORT_W-1:0] value_override_val;    // value driven
    logic [PORT_W-1:0] input_en_override_en;  // input takeover
    logic [PORT_W-1:0] input_en_override_val; // input enable value
    logic [PORT_W-1:0] pin_out_next;          // next pad value
    logic [PORT_W-1:0] oe_n_next;             // next enable
    logic [PORT_W-1:0] pullup_next;           // next pull-up
    logic [PORT_W-1:0] din_en;                // digital input enable
    logic [PORT_W-1:0] sync1_reg;             // first sync stage
    logic [PORT_W-1:0] sync2_reg;             // second sync stage
    logic [1:0]        live_reg;              // cycles since reset
    logic              set_on;                // spi owns this pin set
    logic              slave_cond;            // spi on as slave
    logic              master_cond;           // spi on as master
    logic              pud_n;                 // pull-ups allowed

    assign set_on      = ~SERIAL_PIN_SET_SELECT;
    assign slave_cond  = SERIAL_PERIPH_ON & ~SERIAL_MASTER_SELECT & set_on;
    assign master_cond = SERIAL_PERIPH_ON & SERIAL_MASTER_SELECT & set_on;
    assign pud_n       = ~GLOBAL_PULLUP_DISABLE;

    // ------------------------------------------------------------
    // override terms per pin
    // ------------------------------------------------------------
    // builds every override; untouched cells stay zero
    always_comb
    begin
        pullup_override_en    = RST_ZERO;
        pullup_override_val   = RST_ZERO;
        dir_override_en       = RST_ZERO;
        dir_override_val      = RST_ZERO;
        value_override_en     = RST_ZERO;
        value_override_val    = RST_ZERO;
        input_en_override_en  = RST_ZERO;
        input_en_override_val = RST_ZERO;
        // slave forces input unless stage 0b is enabled, master leaves direction bit
        // forced pin pull-up from output bit and global disable
        pullup_override_en[BIT_SCLK]  = slave_cond;
        pullup_override_val[BIT_SCLK] = OUT[BIT_SCLK] & pud_n;
        // driver override from slave or stage 0b
        dir_override_en[BIT_SCLK]  = slave_cond | STAGE_OUT_B0_ENABLE;
        dir_override_val[BIT_SCLK] = STAGE_OUT_B0_ENABLE;
        value_override_en[BIT_SCLK]  = slave_cond | STAGE_OUT_B0_ENABLE;
        value_override_val[BIT_SCLK] =
            (STAGE_OUT_B0_VALUE & ~STAGE_OUT_B0_ENABLE & set_on) |
            (STAGE_OUT_B0_VALUE & STAGE_OUT_B0_ENABLE & set_on) |
            (STAGE_OUT_B0_VALUE & STAGE_OUT_B0_ENABLE & ~set_on);
        dir_override_en[BIT_STAGE1B]    = STAGE_OUT_B1_ENABLE;
        dir_override_val[BIT_STAGE1B]   = 1'b1;
        value_override_en[BIT_STAGE1B]  = STAGE_OUT_B1_ENABLE;
        value_override_val[BIT_STAGE1B] = STAGE_OUT_B1_VALUE;
        // slave forces bit 1 input, else stage 2b may take it
        // forced pull-up keeps output bit and global disable
        pullup_override_en[BIT_MOSI]  = slave_cond;
        pullup_override_val[BIT_MOSI] = OUT[BIT_MOSI] & pud_n;
        dir_override_en[BIT_MOSI]     = slave_cond | STAGE_OUT_B2_ENABLE;
        // master forces bit 0 input, else stage 2a may take it
        // forced pull-up keeps output bit and global disable
        pullup_override_en[BIT_MISO]  = master_cond;
        pullup_override_val[BIT_MISO] = OUT[BIT_MISO] & pud_n;
        dir_override_en[BIT_MISO]     = master_cond | STAGE_OUT_A2_ENABLE;
        // stage 2a, 2b drive only where the spi forces no input
        dir_override_val[BIT_MOSI]   = STAGE_OUT_B2_ENABLE & ~slave_cond;
        value_override_en[BIT_MOSI]  = STAGE_OUT_B2_ENABLE & ~slave_cond;
        value_override_val[BIT_MOSI] = STAGE_OUTPUT_TWO_B;
        dir_override_val[BIT_MISO]   = STAGE_OUT_A2_ENABLE & ~master_cond;
        value_override_en[BIT_MISO]  = STAGE_OUT_A2_ENABLE & ~master_cond;
        value_override_val[BIT_MISO] = STAGE_OUTPUT_TWO_A;
        input_en_override_en[BIT_SCLK]    = ANALOG4_INPUT_DISABLE;
        input_en_override_en[BIT_STAGE1B] = ANALOG7_INPUT_DISABLE;
        input_en_override_en[BIT_IRQ2]  = ANALOG6_INPUT_DISABLE |
                                          EXT_IRQ2_ENABLE;
        input_en_override_val[BIT_IRQ2] = EXT_IRQ2_ENABLE;
        input_en_override_en[BIT_AMP0P] = AMP0_INPUT_DISABLE;
        input_en_override_en[BIT_AMP0N] = AMP0_INPUT_DISABLE;
        input_en_override_en[BIT_IRQ1]  = ANALOG5_INPUT_DISABLE |
                                          EXT_IRQ1_ENABLE;
        input_en_override_val[BIT_IRQ1] = EXT_IRQ1_ENABLE;
    end
    // ------------------------------------------------------------
    // generic pin cell merge
    // ------------------------------------------------------------
    // folds overrides into the ordinary port controls
    always_comb
    begin
        for (int n = 0; n < PORT_W; n++)
        begin
            pullup_next[n] = pullup_override_en[n] ?
                pullup_override_val[n] :
                (~DIR[n] & OUT[n] & pud_n);
            oe_n_next[n] = ~(dir_override_en[n] ?
                dir_override_val[n] : DIR[n]);
            pin_out_next[n] = value_override_en[n] ?
                value_override_val[n] : OUT[n];
            din_en[n] = input_en_override_en[n] ?
                input_en_override_val[n] : ~SLEEP;
        end
    end
    // ------------------------------------------------------------
    // pad side registers
    // ------------------------------------------------------------
    // registers the pad controls; reset leaves pins undriven
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            PIN_OUT    <= RST_ZERO;
            PIN_OE_N   <= RST_OE_N;
            PIN_PULLUP <= RST_ZERO;
        end
        else
        begin
            PIN_OUT    <= pin_out_next;
            PIN_OE_N   <= oe_n_next;
            PIN_PULLUP <= pullup_next;
        end
    end

    // two-stage synchroniser on the pad levels
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            sync1_reg <= RST_ZERO;
            sync2_reg <= RST_ZERO;
        end
        else
        begin
            sync1_reg <= PIN_IN;
            sync2_reg <= sync1_reg;
        end
    end
    // ------------------------------------------------------------
    // input routing to peripherals
    // ------------------------------------------------------------
    // gates synced levels and hands them to each user
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            DIG_IN              <= RST_ZERO;
            PIN_CHANGE_SRC      <= RST_ZERO;
            EXT_IRQ_2           <= 1'b0;
            EXT_IRQ_1           <= 1'b0;
            SERIAL_CLOCK_IN     <= 1'b0;
            SERIAL_DATA_IN_MOSI <= 1'b0;
            SERIAL_DATA_IN_MISO <= 1'b0;
        end
        else
        begin
            DIG_IN <= sync2_reg & din_en;
            PIN_CHANGE_SRC <= sync2_reg & din_en;
            EXT_IRQ_2 <= sync2_reg[BIT_IRQ2] & din_en[BIT_IRQ2];
            EXT_IRQ_1 <= sync2_reg[BIT_IRQ1] & din_en[BIT_IRQ1];
            SERIAL_CLOCK_IN <= sync2_reg[BIT_SCLK] & din_en[BIT_SCLK] &
                               set_on & CLOCK_IN_GATE_QUAL;
            SERIAL_DATA_IN_MOSI <= sync2_reg[BIT_MOSI] &
                                   din_en[BIT_MOSI] & set_on &
                                   DATA_IN_GATE_QUAL;
            SERIAL_DATA_IN_MISO <= sync2_reg[BIT_MISO] &
                                   din_en[BIT_MISO] & set_on &
                                   DATA_IN_GATE_QUAL;
        end
    end

    // counts settle cycles so checks skip reset history
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            live_reg <= 2'h0;
        else if (live_reg != LIVE_DONE)
            live_reg <= live_reg + 2'h1;
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_slave;
        live_reg == LIVE_DONE && slave_cond && !STAGE_OUT_B0_ENABLE;
    endsequence
    sequence s_mosi_slave;
        live_reg == LIVE_DONE && slave_cond;
    endsequence
    property p_sclk_input;
        s_slave |=> PIN_OE_N[BIT_SCLK];
    endproperty
    a_sclk_input: assert property (p_sclk_input)
        else $error("clock pin drives while spi slave");
    property p_sclk_master;
        (live_reg == LIVE_DONE && master_cond && !STAGE_OUT_B0_ENABLE)
        |=> PIN_OE_N[BIT_SCLK] == !$past(DIR[BIT_SCLK]);
    endproperty
    a_sclk_master: assert property (p_sclk_master)
        else $error("clock pin ignores direction in master");
    property p_sclk_pull;
        s_slave |=> PIN_PULLUP[BIT_SCLK] ==
            ($past(OUT[BIT_SCLK]) && !$past(GLOBAL_PULLUP_DISABLE));
    endproperty
    a_sclk_pull: assert property (p_sclk_pull)
        else $error("forced clock pin pull-up wrong");
    property p_mosi_input;
        s_mosi_slave |=> PIN_OE_N[BIT_MOSI] && PIN_PULLUP[BIT_MOSI] ==
            ($past(OUT[BIT_MOSI]) && !$past(GLOBAL_PULLUP_DISABLE));
    endproperty
    a_mosi_input: assert property (p_mosi_input)
        else $error("bit 1 not forced input in slave");
    property p_miso_input;
        (live_reg == LIVE_DONE && master_cond) |=> PIN_OE_N[BIT_MISO];
    endproperty
    a_miso_input: assert property (p_miso_input)
        else $error("bit 0 not forced input in master");
    property p_stage1b;
        (live_reg == LIVE_DONE && STAGE_OUT_B1_ENABLE) |=>
            !PIN_OE_N[BIT_STAGE1B] &&
            PIN_OUT[BIT_STAGE1B] == $past(STAGE_OUT_B1_VALUE);
    endproperty
    a_stage1b: assert property (p_stage1b)
        else $error("bit 6 not driven by stage 1b");
    property p_analog4_off;
        (live_reg == LIVE_DONE && ANALOG4_INPUT_DISABLE)
        |=> !DIG_IN[BIT_SCLK] && !SERIAL_CLOCK_IN;
    endproperty
    a_analog4_off: assert property (p_analog4_off)
        else $error("bit 7 input alive under analog disable");
    property p_irq2_path;
        (live_reg == LIVE_DONE && EXT_IRQ2_ENABLE)
        ##1 EXT_IRQ2_ENABLE |=> EXT_IRQ_2 == $past(PIN_IN[BIT_IRQ2], 3);
    endproperty
    a_irq2_path: assert property (p_irq2_path)
        else $error("irq 2 does not follow bit 5 pad");
    property p_amp0_off;
        (live_reg == LIVE_DONE && AMP0_INPUT_DISABLE)
        |=> DIG_IN[BIT_AMP0P] == 1'b0 && DIG_IN[BIT_AMP0N] == 1'b0;
    endproperty
    a_amp0_off: assert property (p_amp0_off)
        else $error("amplifier pins input not disabled");
    // pad level three edges back, gated by the enable one edge back
    property p_pcint_match;
        live_reg == LIVE_DONE |->
            PIN_CHANGE_SRC == ($past(PIN_IN, 3) & $past(din_en));
    endproperty
    a_pcint_match: assert property (p_pcint_match)
        else $error("pin change sources do not follow the pads");
endmodule

// file: tb/port_b_alternate_override_tb.sv
`timescale 1ns/100ps
module port_b_alternate_override_tb;
    // --------------------------------------------------------------
    // stimulus and expectation state
    // --------------------------------------------------------------
    logic       MCLK = 1'b0;          // i/o clock
    logic       RESET = 1'b1;         // async reset
    logic [7:0] dir = 8'h00, out = 8'h00, pin_in = 8'h00; // port
    logic       global_pullup_disable = 1'b0, sleep = 1'b0, amp0 = 1'b0;    // globals
    logic       irq2en = 1'b0, irq1en = 1'b0;            // irq enables
    logic [3:0] an = 4'h0;            // analog disables ch 4,5,6,7
    logic [2:0] spi_cmd = 3'h0;       // far side spi command
    logic [7:0] stg_cmd = 8'h00;      // far side stage command
    logic [1:0] qual_cmd = 2'h0;      // far side gate command
    wire  [2:0] spi;                  // spi levels at the block
    wire  [7:0] st;                   // stage levels at the block
    wire  [1:0] qual;                 // gate levels at the block
    logic [7:0] e_oen, e_out, e_pu, e_di; // predicted pad and input
    logic [2:0] e_ser;                // predicted spi inputs
    logic [2:0] modes [4] = '{3'h0, 3'h4, 3'h6, 3'h5}; // off/sl/ms/alt
    int         failures = 0, n_tests = 0; // counters
    wire  [7:0] PIN_OUT, PIN_OE_N, PIN_PULLUP, DIG_IN, PIN_CHANGE_SRC;
    wire        EXT_IRQ_2, EXT_IRQ_1, SCK_IN, MOSI_IN, MISO_IN;

    // clock at 200 MHz
    always #2.5 MCLK = ~MCLK;

    // --------------------------------------------------------------
    // far side and block under test
    // --------------------------------------------------------------
    spi_stage_side far (.mclk(MCLK), .reset(RESET), .spi_cmd(spi_cmd),
        .stage_cmd(stg_cmd), .qual_cmd(qual_cmd), .spi_reg(spi),
        .stage_reg(st), .qual_reg(qual));
    port_b_alternate_override DUT (.MCLK(MCLK), .RESET(RESET),
        .DIR(dir), .OUT(out), .GLOBAL_PULLUP_DISABLE(global_pullup_disable),
        .SLEEP(sleep), .SERIAL_PERIPH_ON(spi[2]),
        .SERIAL_MASTER_SELECT(spi[1]), .SERIAL_PIN_SET_SELECT(spi[0]),
        .STAGE_OUT_B0_ENABLE(st[0]), .STAGE_OUT_B0_VALUE(st[1]),
        .STAGE_OUT_B1_ENABLE(st[2]), .STAGE_OUT_B1_VALUE(st[3]),
        .STAGE_OUT_A2_ENABLE(st[4]), .STAGE_OUTPUT_TWO_A(st[5]),
        .STAGE_OUT_B2_ENABLE(st[6]), .STAGE_OUTPUT_TWO_B(st[7]),
        .ANALOG4_INPUT_DISABLE(an[0]), .ANALOG5_INPUT_DISABLE(an[1]),
        .ANALOG6_INPUT_DISABLE(an[2]), .ANALOG7_INPUT_DISABLE(an[3]),
        .AMP0_INPUT_DISABLE(amp0), .EXT_IRQ2_ENABLE(irq2en),
        .EXT_IRQ1_ENABLE(irq1en), .CLOCK_IN_GATE_QUAL(qual[1]),
        .DATA_IN_GATE_QUAL(qual[0]), .PIN_IN(pin_in),
        .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PIN_PULLUP(PIN_PULLUP),
        .DIG_IN(DIG_IN), .PIN_CHANGE_SRC(PIN_CHANGE_SRC),
        .EXT_IRQ_2(EXT_IRQ_2), .EXT_IRQ_1(EXT_IRQ_1),
        .SERIAL_CLOCK_IN(SCK_IN), .SERIAL_DATA_IN_MOSI(MOSI_IN),
        .SERIAL_DATA_IN_MISO(MISO_IN));

    // --------------------------------------------------------------
    // prediction, comparison and closing
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // works out every output from the levels now at the inputs
    task automatic predict;
        logic so, sl, ms;
        logic [7:0] dv, ov, ie;
        so = ~spi[0];
        sl = spi[2] & ~spi[1] & so;
        ms = spi[2] & spi[1] & so;
        e_pu = ~dir & out & {8{~global_pullup_disable}};
        dv = dir;
        ov = out;
        if (sl) e_pu[7] = out[7] & ~global_pullup_disable;
        if (sl | st[0]) {dv[7], ov[7]} = {st[0], st[1] & (so | st[0])};
        if (st[2]) {dv[6], ov[6]} = {1'b1, st[3]};
        if (sl) {dv[1], e_pu[1]} = {1'b0, out[1] & ~global_pullup_disable};
        else if (st[6]) {dv[1], ov[1]} = {1'b1, st[7]};
        if (ms) {dv[0], e_pu[0]} = {1'b0, out[0] & ~global_pullup_disable};
        else if (st[4]) {dv[0], ov[0]} = {1'b1, st[5]};
        e_oen = ~dv;
        e_out = ov & dv;
        ie = {8{~sleep}};
        if (an[0]) ie[7] = 1'b0;
        if (an[3]) ie[6] = 1'b0;
        if (an[2] | irq2en) ie[5] = irq2en;
        if (amp0) ie[4:3] = 2'h0;
        if (an[1] | irq1en) ie[2] = irq1en;
        e_di = pin_in & ie;
        e_ser = {e_di[7] & so & qual[1], {e_di[1], e_di[0]} & {2{so & qual[0]}}};
    endtask

    // lets inputs settle through far side and synchroniser, then compares
    task automatic check_all;
        repeat (5) @(posedge MCLK);
        #1;
        predict;
        chk("PIN_OE_N", e_oen, PIN_OE_N);
        chk("PIN_OUT", e_out, PIN_OUT & ~e_oen);
        chk("PIN_PULLUP", e_pu, PIN_PULLUP);
        chk("DIG_IN", e_di, DIG_IN);
        chk("PIN_CHANGE_SRC", e_di, PIN_CHANGE_SRC);
        chk("EXT_IRQ", {e_di[5], e_di[2]}, {EXT_IRQ_2, EXT_IRQ_1});
        chk("SERIAL_IN", e_ser, {SCK_IN, MOSI_IN, MISO_IN});
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // spi modes against both direction settings and pull-up disable
    task automatic t_spi_dir;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge MCLK);
            {spi_cmd, global_pullup_disable} <= i[3:0];
            dir <= i[4] ? 8'hff : 8'h00;
            out <= 8'h83;
            check_all;
        end
        $display("test spi_dir done");
    endtask

    // every stage enable and value under each spi mode
    task automatic t_stage;
        for (int j = 0; j < 4; j++)
            for (int i = 0; i < 256; i++)
            begin
                @(posedge MCLK);
                {spi_cmd, stg_cmd, out} <= {modes[j], i[7:0], 8'h55};
                dir <= 8'h00;
                check_all;
            end
        $display("test stage done");
    endtask

    // sleep, analog disables, amplifier disable and irq enables
    task automatic t_inputs;
        for (int i = 0; i < 256; i++)
        begin
            @(posedge MCLK);
            {spi_cmd, stg_cmd} <= 11'h0;
            {sleep, an, amp0, irq2en, irq1en} <= i[7:0];
            pin_in <= i[0] ? 8'hff : 8'ha5;
            // analog pins held input with pull-up off
            {dir, out} <= 16'h0;
            check_all;
        end
        $display("test inputs done");
    endtask

    // spi inputs against pin set select and both gates
    task automatic t_serial;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge MCLK);
            {sleep, an, amp0, irq2en, irq1en} <= 8'h0;
            spi_cmd <= {2'h2, i[0]};
            qual_cmd <= i[2:1];
            pin_in <= i[3] ? 8'hff : 8'h82;
            check_all;
        end
        $display("test serial done");
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge MCLK);
        #1;
        chk("reset PIN_OE_N", 8'hff, PIN_OE_N);
        chk("reset DIG_IN", 8'h00, DIG_IN | PIN_OUT | PIN_PULLUP);
        $display("test reset done");
        repeat (2) @(posedge MCLK);
        RESET <= 1'b0;
        repeat (4) @(posedge MCLK);
        t_spi_dir;
        t_stage;
        t_inputs;
        t_serial;
        end_of_test;
    end

    // cuts a hang short well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge MCLK);
        failures++;
        end_of_test;
    end
endmodule

// file: tb/spi_stage_side.sv
`timescale 1ns/100ps
// --------------------------------------------------------------
// far side model: spi controller, stage outputs, input gates
// --------------------------------------------------------------
module spi_stage_side
(
    input  wire logic       mclk,      // i/o clock
    input  wire logic       reset,     // async, active high
    input  wire logic [2:0] spi_cmd,   // on, master, pin set select
    input  wire logic [7:0] stage_cmd, // en/val pairs 0b,1b,2a,2b
    input  wire logic [1:0] qual_cmd,  // clock gate, data gate
    output logic      [2:0] spi_reg,   // spi control levels
    output logic      [7:0] stage_reg, // stage control levels
    output logic      [1:0] qual_reg   // gate qualifier levels
);
    // controls come from the peripherals' own flops, so they
    // change just after a clock edge and hold between edges
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            // peripherals idle and gates shut after reset
            spi_reg   <= 3'h0;
            stage_reg <= 8'h00;
            qual_reg  <= 2'h0;
        end
        else
        begin
            // take the commanded levels
            spi_reg   <= spi_cmd;
            stage_reg <= stage_cmd;
            qual_reg  <= qual_cmd;
        end
    end
endmodule
